// >>> rtl/serial_port_device.sv
// Control-side serial port: framing, handshake sequencer, flow control and APB registers
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
module serial_port_device import serial_port_pkg::*; #(
	parameter int unsigned clk_hz = `CLK_HZ,
	parameter int unsigned settle_cycles = `SETTLE_CYC
) (
	input wire logic clock,
	input wire logic reset,
	serial_link_if.device link,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic operator_abort_key,
	output logic irq,
	output logic [3:0] led_red,
	output logic [3:0] led_green
);
	logic [2:0] fmt_q, baud_q;
	logic sw_q;
	char_fmt_t cf;
	logic [24:0] div;
	link_state_t state_q;
	logic [24:0] settle_q;
	logic ctrl_q, key_q, remote_ok, abort_ev;
	logic [31:0] prdata_q, rdata;
	logic pready_q, pslverr_q, hit, acc, wr_ev, rd_ev, start, stop, tx_wr, rx_pop;
	logic [7:0] txh_q;
	logic txh_v_q, tx_go, tx_done;
	logic [11:0] tsh_q, frame;
	logic [3:0] tleft_q, ttotal;
	logic [24:0] tcnt_q;
	logic rprev_q, rbusy_q, rx_fin, rx_take, is_flow, perr, ferr, xoff_q;
	logic [3:0] ridx_q, rlast;
	logic [11:0] rbits_q;
	logic [24:0] rcnt_q;
	logic [7:0] rdat, rxd_q;
	logic rxv_q;
	logic [`IRQ_W-1:0] sts_q, mask_q, irq_set, irq_clr;
	logic irq_q;
	logic [3:0] red_q, green_q, sig;

	assign cf = decode_fmt(fmt_q);
	assign div = baud_div(baud_q, clk_hz);
	assign remote_ok = sw_q | link.stat_in;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// One wait state so every bus output comes from a flop
	assign acc = psel & penable & pready_q;
	assign wr_ev = acc & pwrite & hit;
	assign rd_ev = acc & ~pwrite & hit;
	assign start = wr_ev && paddr == `OFS_CONTROL && pwdata[`CTL_START_BIT];
	assign stop = wr_ev && paddr == `OFS_CONTROL && pwdata[`CTL_STOP_BIT];
	assign tx_wr = wr_ev && paddr == `OFS_TXDATA;
	assign rx_pop = rd_ev && paddr == `OFS_RXDATA;
	assign irq_clr = (wr_ev && paddr == `OFS_IRQ_STATUS) ? pwdata[`IRQ_W-1:0] : '0;

	always_comb begin
		hit = 1'b1;
		rdata = '0;
		case (paddr)
			`OFS_CONFIG: begin
				rdata[`CFG_FMT_LSB +: 3] = fmt_q;
				rdata[`CFG_BAUD_LSB +: 3] = baud_q;
				rdata[`CFG_SW_BIT] = sw_q;
			end
			`OFS_CONTROL: rdata = '0;
			`OFS_STATUS: begin
				rdata[2:0] = state_q;
				rdata[`STS_TX_BUSY_BIT] = tleft_q != 4'h0;
				rdata[`STS_TX_FULL_BIT] = txh_v_q;
				rdata[`STS_RX_VALID_BIT] = rxv_q;
				rdata[`STS_XOFF_BIT] = xoff_q;
			end
			`OFS_IRQ_STATUS: rdata[`IRQ_W-1:0] = sts_q;
			`OFS_IRQ_MASK: rdata[`IRQ_W-1:0] = mask_q;
			`OFS_TXDATA: rdata = '0;
			`OFS_RXDATA: rdata[7:0] = rxd_q;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q) begin
				prdata_q <= pwrite ? '0 : rdata;
				pslverr_q <= ~hit;
			end
		end
	end

	// Format may only change while the sequencer is in ST_IDLE
	always_ff @(posedge clock) begin
		if (reset) begin
			fmt_q <= `FMT_DEFAULT;
			baud_q <= `BAUD_DEFAULT;
			sw_q <= 1'b0;
		end else if (wr_ev && paddr == `OFS_CONFIG && state_q == ST_IDLE) begin
			fmt_q <= pwdata[`CFG_FMT_LSB +: 3];
			baud_q <= pwdata[`CFG_BAUD_LSB +: 3];
			sw_q <= pwdata[`CFG_SW_BIT];
		end
	end

	// ----------------------------------------
	// Handshake sequencer
	// ----------------------------------------
	assign abort_ev = operator_abort_key & ~key_q & (state_q != ST_IDLE);

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q <= ST_IDLE;
			settle_q <= '0;
			key_q <= 1'b0;
			ctrl_q <= 1'b0;
		end else begin
			key_q <= operator_abort_key;
			ctrl_q <= state_q != ST_IDLE;
			if (abort_ev | stop) begin
				state_q <= ST_IDLE;
			end else begin
				case (state_q)
					ST_IDLE: if (start) state_q <= ST_WAIT_REMOTE;
					ST_WAIT_REMOTE: begin
						if (remote_ok) begin
							state_q <= ST_SETTLE;
							settle_q <= 25'(settle_cycles - 1);
						end
					end
					ST_SETTLE: begin
						if (!remote_ok) state_q <= ST_PAUSED;
						else if (settle_q == '0) state_q <= ST_ACTIVE;
						else settle_q <= settle_q - 25'h1;
					end
					ST_ACTIVE: if (!remote_ok) state_q <= ST_PAUSED;
					ST_PAUSED: if (remote_ok) state_q <= ST_ACTIVE;
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	// A frame already on the wire finishes when paused; only new frames wait
	assign tx_go = txh_v_q & (tleft_q == 4'h0) & (state_q == ST_ACTIVE) & ~(sw_q & xoff_q);
	assign ttotal = 4'h3 + cf.nbits + {3'h0, cf.par_en};
	assign tx_done = (tleft_q == 4'h1) && (tcnt_q == '0);

	always_comb begin
		frame = '1;
		frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < cf.nbits) frame[i + 1] = txh_q[i];
		end
		if (cf.par_en) frame[cf.nbits + 4'h1] = parity(txh_q, cf);
	end

	always_ff @(posedge clock) begin
		if (reset || abort_ev) begin
			tsh_q <= '1;
			tleft_q <= '0;
			tcnt_q <= '0;
		end else if (tx_go) begin
			tsh_q <= frame;
			tleft_q <= ttotal;
			tcnt_q <= div - 25'h1;
		end else if (tleft_q != 4'h0) begin
			if (tcnt_q == '0) begin
				tsh_q <= {1'b1, tsh_q[11:1]};
				tleft_q <= tleft_q - 4'h1;
				tcnt_q <= div - 25'h1;
			end else begin
				tcnt_q <= tcnt_q - 25'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset || abort_ev || stop) begin
			txh_v_q <= 1'b0;
			txh_q <= '0;
		end else if (tx_go) begin
			txh_v_q <= 1'b0;
		end else if (tx_wr && !txh_v_q) begin
			txh_q <= pwdata[7:0];
			txh_v_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	// Only the first stop bit is sampled, so one or two are both fine
	assign rlast = cf.nbits + {3'h0, cf.par_en} + 4'h1;
	assign rx_fin = rbusy_q && rcnt_q == '0 && ridx_q == rlast;
	assign rdat = (cf.nbits == 4'h8) ? rbits_q[8:1] : {1'b0, rbits_q[7:1]};
	assign perr = cf.par_en && (parity(rdat, cf) != rbits_q[cf.nbits + 4'h1]);
	assign ferr = ~link.host_txd;
	assign rx_take = rx_fin && (state_q == ST_ACTIVE || state_q == ST_PAUSED);
	assign is_flow = sw_q && (rdat == `XON_CHAR || rdat == `XOFF_CHAR);

	always_ff @(posedge clock) begin
		if (reset) begin
			rprev_q <= 1'b1;
			rbusy_q <= 1'b0;
			ridx_q <= '0;
			rcnt_q <= '0;
			rbits_q <= '0;
		end else begin
			rprev_q <= link.host_txd;
			if (!rbusy_q) begin
				if (rprev_q && !link.host_txd) begin
					rbusy_q <= 1'b1;
					ridx_q <= '0;
					rcnt_q <= div >> 1;
				end
			end else if (rcnt_q != '0) begin
				rcnt_q <= rcnt_q - 25'h1;
			end else begin
				rbits_q[ridx_q] <= link.host_txd;
				ridx_q <= ridx_q + 4'h1;
				rcnt_q <= div - 25'h1;
				if ((ridx_q == 4'h0 && link.host_txd) || ridx_q == rlast) rbusy_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset || state_q == ST_IDLE) begin
			xoff_q <= 1'b0;
		end else if (rx_take && sw_q && !ferr) begin
			if (rdat == `XOFF_CHAR) xoff_q <= 1'b1;
			else if (rdat == `XON_CHAR) xoff_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			rxv_q <= 1'b0;
			rxd_q <= '0;
		end else if (rx_take && !is_flow) begin
			rxv_q <= 1'b1;
			rxd_q <= rdat;
		end else if (rx_pop) begin
			rxv_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Interrupts and indicators
	// ----------------------------------------
	assign irq_set = {rx_take & ~is_flow & rxv_q & ~rx_pop, abort_ev, rx_take & ferr, rx_take & perr,
		tx_done & ~abort_ev, rx_take & ~is_flow};
	assign sig = {link.stat_in, ctrl_q, link.host_txd, tsh_q[0]};

	always_ff @(posedge clock) begin
		if (reset) begin
			sts_q <= '0;
			mask_q <= '0;
			irq_q <= 1'b0;
			red_q <= 4'h0;
			green_q <= 4'hF;
		end else begin
			sts_q <= (sts_q & ~irq_clr) | irq_set;
			if (wr_ev && paddr == `OFS_IRQ_MASK) mask_q <= pwdata[`IRQ_W-1:0];
			irq_q <= |(sts_q & mask_q);
			red_q <= sig;
			green_q <= ~sig;
		end
	end

	assign link.dev_txd = tsh_q[0];
	assign link.ctrl_out = ctrl_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign led_red = red_q;
	assign led_green = green_q;
endmodule

// >>> rtl/serial_port_cfg.svh
// Constants of the serial port: timing, character codes, register map and field positions
`ifndef SERIAL_PORT_CFG_SVH
`define SERIAL_PORT_CFG_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 20000000
`define SETTLE_MS 1000
`define SETTLE_CYC ((`CLK_HZ / 1000) * `SETTLE_MS)
`define BAUD_RATE_1 110
`define BAUD_RATE_2 300
`define BAUD_RATE_3 600
`define BAUD_RATE_4 1200
`define BAUD_RATE_5 2400
`define BAUD_RATE_6 4800
`define BAUD_RATE_7 9600

// ----------------------------------------
// Character codes and reset values
// ----------------------------------------
`define XON_CHAR 8'h11
`define XOFF_CHAR 8'h13
`define FMT_DEFAULT 3'h3
`define BAUD_DEFAULT 3'h7

// ----------------------------------------
// Register map, byte addresses
// ----------------------------------------
`define APB_AW 12
`define OFS_CONFIG 12'h000
`define OFS_CONTROL 12'h004
`define OFS_STATUS 12'h008
`define OFS_IRQ_STATUS 12'h00C
`define OFS_IRQ_MASK 12'h010
`define OFS_TXDATA 12'h014
`define OFS_RXDATA 12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_FMT_LSB 0
`define CFG_BAUD_LSB 4
`define CFG_SW_BIT 8
`define CTL_START_BIT 0
`define CTL_STOP_BIT 1
`define STS_TX_BUSY_BIT 3
`define STS_TX_FULL_BIT 4
`define STS_RX_VALID_BIT 5
`define STS_XOFF_BIT 6
`define IRQ_W 6
`endif

// >>> rtl/serial_port_pkg.sv
// Types and character-format helpers shared by both ends of the serial link
package serial_port_pkg;
`include "serial_port_cfg.svh"

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAIT_REMOTE = 3'b001,
		ST_SETTLE = 3'b010,
		ST_ACTIVE = 3'b011,
		ST_PAUSED = 3'b100
	} link_state_t;

	typedef struct packed {
		logic [3:0] nbits;
		logic par_en;
		logic par_odd;
	} char_fmt_t;

	function automatic char_fmt_t decode_fmt(input logic [2:0] code);
		case (code)
			3'h1: return '{4'h7, 1'b0, 1'b0};
			3'h2: return '{4'h8, 1'b0, 1'b0};
			3'h4: return '{4'h8, 1'b1, 1'b0};
			3'h5: return '{4'h7, 1'b1, 1'b1};
			3'h6: return '{4'h8, 1'b1, 1'b1};
			// Tape code: seven code bits with odd parity
			3'h7: return '{4'h7, 1'b1, 1'b1};
			default: return '{4'h7, 1'b1, 1'b0};
		endcase
	endfunction

	function automatic logic [24:0] baud_div(input logic [2:0] code, input int unsigned clk_hz);
		case (code)
			3'h1: return 25'(clk_hz / `BAUD_RATE_1);
			3'h2: return 25'(clk_hz / `BAUD_RATE_2);
			3'h3: return 25'(clk_hz / `BAUD_RATE_3);
			3'h4: return 25'(clk_hz / `BAUD_RATE_4);
			3'h5: return 25'(clk_hz / `BAUD_RATE_5);
			3'h6: return 25'(clk_hz / `BAUD_RATE_6);
			default: return 25'(clk_hz / `BAUD_RATE_7);
		endcase
	endfunction

	function automatic logic parity(input logic [7:0] d, input char_fmt_t f);
		return (^(f.nbits == 4'h8 ? d : {1'b0, d[6:0]})) ^ f.par_odd;
	endfunction
endpackage

// >>> rtl/serial_link_if.sv
// Serial link wires between the control port and the remote party
`timescale 1ns/1ps
interface serial_link_if;
	logic dev_txd;
	logic host_txd;
	logic ctrl_out;
	logic stat_in;
	modport device(output dev_txd, output ctrl_out, input host_txd, input stat_in);
	modport host(input dev_txd, input ctrl_out, output host_txd, output stat_in);
endinterface

// >>> rtl/serial_port_host.sv
// Remote-party end of the serial link: status line, framing and XON/XOFF response
`timescale 1ns/1ps
module serial_port_host import serial_port_pkg::*; #(
	parameter int unsigned clk_hz = `CLK_HZ
) (
	input wire logic clock,
	input wire logic reset,
	serial_link_if.host link,
	input wire logic [2:0] fmt,
	input wire logic [2:0] baud,
	input wire logic sw_flow,
	input wire logic port_enable,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic rx_error
);
	char_fmt_t cf;
	logic [24:0] div, tcnt_q, rcnt_q;
	logic [11:0] tsh_q, frame, rbits_q;
	logic [3:0] tleft_q, ridx_q, rlast;
	logic stat_q, rdy_q, xoff_q, allowed, take, rprev_q, rbusy_q, rx_fin;
	logic [7:0] rdat, rxd_q;
	logic rxv_q, rxe_q, is_flow;

	assign cf = decode_fmt(fmt);
	assign div = baud_div(baud, clk_hz);
	assign allowed = port_enable & (sw_flow | link.ctrl_out) & ~(sw_flow & xoff_q);
	assign take = tx_valid & rdy_q;

	// ----------------------------------------
	// Transmitter
	// ----------------------------------------
	always_comb begin
		frame = '1;
		frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < cf.nbits) frame[i + 1] = tx_data[i];
		end
		if (cf.par_en) frame[cf.nbits + 4'h1] = parity(tx_data, cf);
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			tsh_q <= '1;
			tleft_q <= '0;
			tcnt_q <= '0;
			rdy_q <= 1'b0;
			stat_q <= 1'b0;
		end else begin
			stat_q <= port_enable;
			rdy_q <= (tleft_q == 4'h0) & allowed & ~take;
			if (take) begin
				tsh_q <= frame;
				tleft_q <= 4'h3 + cf.nbits + {3'h0, cf.par_en};
				tcnt_q <= div - 25'h1;
			end else if (tleft_q != 4'h0) begin
				if (tcnt_q == '0) begin
					tsh_q <= {1'b1, tsh_q[11:1]};
					tleft_q <= tleft_q - 4'h1;
					tcnt_q <= div - 25'h1;
				end else begin
					tcnt_q <= tcnt_q - 25'h1;
				end
			end
		end
	end

	// ----------------------------------------
	// Receiver
	// ----------------------------------------
	assign rlast = cf.nbits + {3'h0, cf.par_en} + 4'h1;
	assign rx_fin = rbusy_q && rcnt_q == '0 && ridx_q == rlast;
	assign rdat = (cf.nbits == 4'h8) ? rbits_q[8:1] : {1'b0, rbits_q[7:1]};
	assign is_flow = sw_flow && (rdat == `XON_CHAR || rdat == `XOFF_CHAR);

	always_ff @(posedge clock) begin
		if (reset) begin
			rprev_q <= 1'b1;
			rbusy_q <= 1'b0;
			ridx_q <= '0;
			rcnt_q <= '0;
			rbits_q <= '0;
		end else begin
			rprev_q <= link.dev_txd;
			if (!rbusy_q) begin
				if (rprev_q && !link.dev_txd) begin
					rbusy_q <= 1'b1;
					ridx_q <= '0;
					rcnt_q <= div >> 1;
				end
			end else if (rcnt_q != '0) begin
				rcnt_q <= rcnt_q - 25'h1;
			end else begin
				rbits_q[ridx_q] <= link.dev_txd;
				ridx_q <= ridx_q + 4'h1;
				rcnt_q <= div - 25'h1;
				if ((ridx_q == 4'h0 && link.dev_txd) || ridx_q == rlast) rbusy_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			xoff_q <= 1'b0;
			rxv_q <= 1'b0;
			rxe_q <= 1'b0;
			rxd_q <= '0;
		end else begin
			rxv_q <= rx_fin & ~is_flow;
			rxe_q <= rx_fin & (~link.dev_txd | (cf.par_en & (parity(rdat, cf) != rbits_q[cf.nbits + 4'h1])));
			if (rx_fin) rxd_q <= rdat;
			if (!sw_flow) xoff_q <= 1'b0;
			else if (rx_fin && rdat == `XOFF_CHAR) xoff_q <= 1'b1;
			else if (rx_fin && rdat == `XON_CHAR) xoff_q <= 1'b0;
		end
	end

	assign link.host_txd = tsh_q[0];
	assign link.stat_in = stat_q;
	assign tx_ready = rdy_q;
	assign rx_data = rxd_q;
	assign rx_valid = rxv_q;
	assign rx_error = rxe_q;
endmodule

// >>> verification/serial_port_framing_handshake_chk.sv
// Link-level assertions for the joined device and host ends
`timescale 1ns/1ps
module serial_port_framing_handshake_chk #(
	parameter int div = 20,
	parameter int settle = 50
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic dev_txd,
	input wire logic host_txd,
	input wire logic ctrl_out,
	input wire logic stat_in
);
	logic [15:0] dev_low_q, dev_high_q, host_low_q, host_high_q;
	logic [31:0] ready_q;
	logic [15:0] dev_since_q, host_since_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// ----------------------------------------
	// Run-length counters
	// ----------------------------------------
	// High counters saturate so a long idle never wraps into a short one
	always_ff @(posedge clock) begin
		if (reset) begin
			dev_low_q <= 16'h0000;
			host_low_q <= 16'h0000;
			dev_high_q <= 16'hFFFF;
			host_high_q <= 16'hFFFF;
		end else begin
			dev_low_q <= dev_txd ? 16'h0000 : dev_low_q + 16'h0001;
			host_low_q <= host_txd ? 16'h0000 : host_low_q + 16'h0001;
			dev_high_q <= !dev_txd ? 16'h0000 : (dev_high_q == 16'hFFFF ? dev_high_q : dev_high_q + 16'h0001);
			host_high_q <= !host_txd ? 16'h0000 : (host_high_q == 16'hFFFF ? host_high_q : host_high_q + 16'h0001);
		end
	end

	// Cycles since the last start bit; falls inside a frame are data, not starts
	always_ff @(posedge clock) begin
		if (reset) begin
			dev_since_q <= 16'hFFFF;
			host_since_q <= 16'hFFFF;
		end else begin
			dev_since_q <= (!dev_txd && dev_high_q != 16'h0000 && dev_since_q >= 16'(12 * div)) ? 16'h0000 :
				(dev_since_q == 16'hFFFF ? dev_since_q : dev_since_q + 16'h0001);
			host_since_q <= (!host_txd && host_high_q != 16'h0000 && host_since_q >= 16'(12 * div)) ? 16'h0000 :
				(host_since_q == 16'hFFFF ? host_since_q : host_since_q + 16'h0001);
		end
	end

	// Cycles since the remote first answered; a later drop does not restart it
	always_ff @(posedge clock) begin
		if (reset || !ctrl_out) begin
			ready_q <= 32'h0000_0000;
		end else if ((stat_in || ready_q != 32'h0000_0000) && ready_q != 32'hFFFF_FFFF) begin
			ready_q <= ready_q + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	dev_two_stop_a: assert property ($fell(dev_txd) && dev_since_q >= 16'(12 * div) |-> dev_high_q >= 16'(2 * div))
		else $error("device start bit came less than two bit times after a frame");
	host_two_stop_a: assert property ($fell(host_txd) && host_since_q >= 16'(12 * div) |-> host_high_q >= 16'(2 * div))
		else $error("host start bit came less than two bit times after a frame");
	dev_min_bit_a: assert property ($rose(dev_txd) |-> dev_low_q >= 16'(div))
		else $error("device low pulse shorter than one bit");
	host_min_bit_a: assert property ($rose(host_txd) |-> host_low_q >= 16'(div))
		else $error("host low pulse shorter than one bit");
	settle_wait_a: assert property ($fell(dev_txd) |-> ready_q >= 32'(settle - 2))
		else $error("device sent before the settle delay ran out");
	send_needs_ctrl_a: assert property ($fell(dev_txd) |-> ctrl_out)
		else $error("device sent without its status output raised");
	pause_holds_a: assert property (!stat_in [*3] |-> !$fell(dev_txd))
		else $error("device started a frame while the remote was not ready");
	host_needs_ctrl_a: assert property (!ctrl_out [*3] |-> !$fell(host_txd))
		else $error("host sent while the device status output was low");
endmodule

// >>> verification/serial_port_framing_handshake_test.sv
// Self-checking bench: device and host ends joined, device driven over APB
`timescale 1ns/1ps
`include "serial_port_cfg.svh"
module serial_port_framing_handshake_test;
	localparam int clk_rate = 200000;
	localparam int settle_n = 50;
	localparam int bit_div = clk_rate / 9600;
	int rates[7] = '{110, 300, 600, 1200, 2400, 4800, 9600};
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, abort_key = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, irq, err;
	logic [3:0] led_red, led_green;
	logic [2:0] fmt = 3'h3, baud = 3'h7;
	logic sw_flow = 1'b0, port_enable = 1'b0, tx_valid = 1'b0, tx_ready, rx_valid, rx_error;
	logic [7:0] tx_data = 8'h00, rx_data, c;
	int mismatches = 0, cmp_count = 0, cycles = 0;

	serial_link_if serial_link_if_i();
	serial_port_device #(.clk_hz(clk_rate), .settle_cycles(settle_n)) serial_port_device_i (.clock(clock),
		.reset(reset), .link(serial_link_if_i.device), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.operator_abort_key(abort_key), .irq(irq), .led_red(led_red), .led_green(led_green));
	serial_port_host #(.clk_hz(clk_rate)) serial_port_host_i (.clock(clock), .reset(reset),
		.link(serial_link_if_i.host), .fmt(fmt), .baud(baud), .sw_flow(sw_flow), .port_enable(port_enable),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_error(rx_error));
	serial_port_framing_handshake_chk #(.div(bit_div), .settle(settle_n)) serial_port_framing_handshake_chk_i (
		.clock(clock), .reset(reset), .dev_txd(serial_link_if_i.dev_txd), .host_txd(serial_link_if_i.host_txd),
		.ctrl_out(serial_link_if_i.ctrl_out), .stat_in(serial_link_if_i.stat_in));

	initial begin
		forever #25 clock = ~clock;
	end

	// ----------------------------------------
	// Stimulus and observation tasks
	// ----------------------------------------
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Entered just after a rising edge; returns one edge after release
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			apb(1'b0, `OFS_STATUS, 32'h0000_0000);
			n++;
		end while ((rd & m) !== v && n < 300);
		check(rd & m, v, "status field");
	endtask

	task automatic host_send(input logic [7:0] d);
		tx_data <= d;
		tx_valid <= 1'b1;
		do @(posedge clock); while (tx_ready !== 1'b1);
		tx_valid <= 1'b0;
		@(posedge clock);
	endtask

	task automatic host_get(input logic [7:0] d);
		do @(posedge clock); while (rx_valid !== 1'b1);
		check(rx_data, d, "host received");
	endtask

	// Samples twelve bit cells from mid start bit; cells past the frame must be idle
	task automatic capture(input logic [7:0] d, input logic [2:0] f, input int dv);
		logic [11:0] exp, got;
		logic p;
		int nb;
		nb = (f == 3'h2 || f == 3'h4 || f == 3'h6) ? 8 : 7;
		exp = 12'hFFE;
		p = 1'b0;
		for (int k = 0; k < nb; k++) begin
			exp[k + 1] = d[k];
			p = p ^ d[k];
		end
		if (f >= 3'h3) begin
			exp[nb + 1] = p ^ (f >= 3'h5);
		end
		do @(posedge clock); while (serial_link_if_i.dev_txd !== 1'b0);
		repeat (dv / 2) @(posedge clock);
		for (int k = 0; k < 12; k++) begin
			got[k] = serial_link_if_i.dev_txd;
			repeat (dv) @(posedge clock);
		end
		check(got, exp, "frame on wire");
	endtask

	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge clock);
			if (serial_link_if_i.dev_txd !== 1'b1) seen = 1'b1;
		end
		check(seen, 1'b0, "line idle");
	endtask

	// Ceiling well above the slowest expected run of about 41k cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			mismatches++;
			results();
		end
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		repeat (3) @(posedge clock);
		check(led_red, 4'h3, "red leds");
		check(led_green, 4'hC, "green leds");
		apb(1'b0, `OFS_CONFIG, 32'h0000_0000);
		check(rd, 32'h0000_0073, "config reset");
		apb(1'b0, 12'h01C, 32'h0000_0000);
		check({31'h0, err}, 32'h1, "unmapped error");
		port_enable <= 1'b1;
		$display("test reset done");
		for (int i = 1; i <= 7; i++) begin
			c = 8'hC1 + 8'(2 * i);
			fmt <= 3'(i);
			baud <= 3'(i);
			apb(1'b1, `OFS_CONFIG, 32'(i) | (32'(i) << 4));
			apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
			poll(32'h7, 32'h3);
			fork
				apb(1'b1, `OFS_TXDATA, 32'(c));
				capture(c, 3'(i), clk_rate / rates[i - 1]);
				host_get((i % 2 == 1) ? {1'b0, c[6:0]} : c);
				host_send(8'hB6 + 8'(i));
			join
			poll(32'h20, 32'h20);
			apb(1'b0, `OFS_RXDATA, 32'h0000_0000);
			c = 8'hB6 + 8'(i);
			check(rd, (i % 2 == 1) ? {25'h0, c[6:0]} : {24'h0, c}, "device received");
			apb(1'b1, `OFS_CONTROL, 32'h0000_0002);
		end
		$display("test formats done");
		fmt <= 3'h3;
		baud <= 3'h7;
		apb(1'b1, `OFS_CONFIG, 32'h0000_0073);
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0000);
		apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_003F);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
		poll(32'h7, 32'h3);
		port_enable <= 1'b0;
		poll(32'h7, 32'h4);
		apb(1'b1, `OFS_TXDATA, 32'h0000_005A);
		quiet(10 * bit_div);
		port_enable <= 1'b1;
		fork
			capture(8'h5A, 3'h3, bit_div);
			host_get(8'h5A);
		join
		check({31'h0, irq}, 32'h0, "masked irq");
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0002, "tx done status");
		apb(1'b1, `OFS_IRQ_MASK, 32'h0000_0002);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h1, "irq raised");
		apb(1'b1, `OFS_IRQ_STATUS, 32'h0000_0002);
		repeat (2) @(posedge clock);
		check({31'h0, irq}, 32'h0, "irq cleared");
		apb(1'b1, `OFS_CONTROL, 32'h0000_0002);
		$display("test pause and irq done");
		sw_flow <= 1'b1;
		apb(1'b1, `OFS_CONFIG, 32'h0000_0173);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
		poll(32'h7, 32'h3);
		host_send(8'h13);
		poll(32'h40, 32'h40);
		check(rd & 32'h20, 32'h0, "flow char kept back");
		apb(1'b1, `OFS_TXDATA, 32'h0000_004B);
		quiet(15 * bit_div);
		fork
			capture(8'h4B, 3'h3, bit_div);
			host_get(8'h4B);
			host_send(8'h11);
		join
		apb(1'b1, `OFS_CONTROL, 32'h0000_0002);
		$display("test software flow done");
		sw_flow <= 1'b0;
		port_enable <= 1'b0;
		apb(1'b1, `OFS_CONFIG, 32'h0000_0073);
		apb(1'b1, `OFS_CONTROL, 32'h0000_0001);
		repeat (4) @(posedge clock);
		check({31'h0, serial_link_if_i.ctrl_out}, 32'h1, "status output up");
		check({31'h0, led_red[2]}, 32'h1, "status output led");
		poll(32'h7, 32'h1);
		abort_key <= 1'b1;
		repeat (3) @(posedge clock);
		abort_key <= 1'b0;
		repeat (3) @(posedge clock);
		check({31'h0, serial_link_if_i.ctrl_out}, 32'h0, "status output down");
		apb(1'b0, `OFS_IRQ_STATUS, 32'h0000_0000);
		check(rd & 32'h10, 32'h10, "abort flag");
		poll(32'h7, 32'h0);
		$display("test abort done");
		results();
	end
endmodule
